// ### pkg/adcctl_defines.svh
// register offsets, field positions, reset values and timing counts of the conversion control block
`ifndef ADCCTL_DEFINES_SVH
`define ADCCTL_DEFINES_SVH

// register offsets
`define ADCCTL_OFS_CTRL 8'hE1
`define ADCCTL_OFS_RESULT_HIGH 8'hE2
`define ADCCTL_OFS_CTRL_EXT 8'hE3
`define ADCCTL_OFS_PIN_DISABLE 8'hF6
`define ADCCTL_OFS_MISC 8'hE4

// main control register fields
`define ADCCTL_CTRL_RES_HI 7
`define ADCCTL_CTRL_RES_LO 6
`define ADCCTL_CTRL_EXT_TRIG 5
`define ADCCTL_CTRL_DONE 4
`define ADCCTL_CTRL_START 3
`define ADCCTL_CTRL_CLK_SRC 2
`define ADCCTL_CTRL_CH1 1
`define ADCCTL_CTRL_CH0 0

// extension control register fields
`define ADCCTL_EXT_PRE_HI 7
`define ADCCTL_EXT_PRE_LO 6
`define ADCCTL_EXT_CH2 2

// miscellaneous register fields
`define ADCCTL_MISC_ENABLE 0
`define ADCCTL_MISC_RC_FREQ 1

// reset values
`define ADCCTL_PRESCALE_RESET 2'h2
`define ADCCTL_BYTE_ZERO 8'h00

// conversion length in converter clock ticks
`define ADCCTL_CONV_TICKS 5'h0B
`define ADCCTL_TICK_ZERO 5'h00
`define ADCCTL_TICK_ONE 5'h01
`define ADCCTL_PRESCALE_DIV1 2'h0
`define ADCCTL_DIV_ONE 3'h1

`endif

// ### pkg/adcctl_pkg.sv
// types of the conversion control block
package adcctl_pkg;
  typedef enum logic [1:0] {
    ADCCTL_IDLE,
    ADCCTL_CONVERT,
    ADCCTL_FINISH
  } adcctl_state_type;

  typedef struct packed {
    adcctl_state_type state;
    logic done;
    logic start_busy;
    logic ext_trig_en;
    logic clk_src;
    logic [2:0] channel;
    logic [1:0] prescale;
    logic [9:0] result;
    logic [7:0] pin_disable;
    logic conv_enable;
    logic rc_freq;
    logic [2:0] div_cnt;
    logic [4:0] ticks;
    logic [9:0] sample;
    logic trig_meta;
    logic trig_sync;
    logic trig_prev;
    logic [7:0] rd_data;
    logic conv_clk_tick;
  } adcctl_regs_type;
endpackage

// ### rtl/adcctl_top.sv
// conversion control for an eight channel ten bit analog converter
`timescale 1ns/1ps
`include "adcctl_defines.svh"

module adcctl_top #(
  parameter int RESULT_WIDTH = 10 // converter result width
) (
  input wire logic core_clk, // system clock, 125 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, one cycle after read strobe
  input wire logic rc_clk_tick, // internal rc oscillator tick, same domain
  input wire logic external_trigger_pin, // asynchronous trigger pin
  input wire logic [9:0] core_result, // result from the analog core
  input wire logic core_ready, // analog core finished its sample
  output logic conv_tick, // prescaled clock tick to the converter
  output logic conv_active, // converter running
  output logic [2:0] conv_channel, // selected analog input
  output logic conv_rc_source, // converter clock taken from rc oscillator
  output logic conv_rc_fast, // rc oscillator at its higher frequency
  output logic conv_irq_req, // done flag, to the interrupt controller
  output logic [7:0] pin_digital_off // digital input disable per port pin
);

  adcctl_pkg::adcctl_regs_type r;
  adcctl_pkg::adcctl_regs_type next_r;

  logic wr_ctrl;
  logic wr_ext;
  logic wr_pin;
  logic wr_misc;
  logic trig_edge;
  logic start_req;
  logic src_tick;
  logic div_hit;

  // register decode
  assign wr_ctrl = reg_wr && (reg_addr == `ADCCTL_OFS_CTRL);
  assign wr_ext = reg_wr && (reg_addr == `ADCCTL_OFS_CTRL_EXT);
  assign wr_pin = reg_wr && (reg_addr == `ADCCTL_OFS_PIN_DISABLE);
  assign wr_misc = reg_wr && (reg_addr == `ADCCTL_OFS_MISC);

  // trigger edge on the synchronised pin
  assign trig_edge = r.trig_sync && !r.trig_prev && r.ext_trig_en;

  // selected source clock tick: cpu clock every cycle or rc tick
  assign src_tick = r.clk_src ? rc_clk_tick : 1'b1;

  // prescaler terminal count
  always_comb begin
    unique case (r.prescale)
      2'h0: div_hit = 1'b1;
      2'h1: div_hit = (r.div_cnt[0] == 1'b1);
      2'h2: div_hit = (r.div_cnt[1:0] == 2'h3);
      default: div_hit = (r.div_cnt == 3'h7);
    endcase
  end

  // a start request from software or the trigger pin
  assign start_req = (wr_ctrl && reg_wdata[`ADCCTL_CTRL_START]) || trig_edge;

  // next state of the whole block
  always_comb begin
    next_r = r;
    next_r.trig_meta = external_trigger_pin;
    next_r.trig_sync = r.trig_meta;
    next_r.trig_prev = r.trig_sync;
    next_r.conv_clk_tick = 1'b0;
    next_r.rd_data = `ADCCTL_BYTE_ZERO;
    // prescaler runs only while the converter is enabled
    if (r.conv_enable && src_tick) begin
      next_r.div_cnt = r.div_cnt + `ADCCTL_DIV_ONE;
      next_r.conv_clk_tick = div_hit;
    end
    // software writes
    if (wr_ctrl) begin
      next_r.ext_trig_en = reg_wdata[`ADCCTL_CTRL_EXT_TRIG];
      if (!r.conv_enable) begin
        next_r.clk_src = reg_wdata[`ADCCTL_CTRL_CLK_SRC];
      end
      if (!r.done && !r.start_busy) begin
        next_r.channel[1:0] = reg_wdata[`ADCCTL_CTRL_CH1:`ADCCTL_CTRL_CH0];
      end
      if (!reg_wdata[`ADCCTL_CTRL_DONE]) begin
        next_r.done = 1'b0;
      end
      if (!reg_wdata[`ADCCTL_CTRL_START] && r.start_busy) begin
        next_r.start_busy = 1'b0;
        next_r.state = adcctl_pkg::ADCCTL_IDLE;
      end
    end
    if (wr_ext) begin
      next_r.prescale = reg_wdata[`ADCCTL_EXT_PRE_HI:`ADCCTL_EXT_PRE_LO];
      if (!r.done && !r.start_busy) begin
        next_r.channel[2] = reg_wdata[`ADCCTL_EXT_CH2];
      end
    end
    if (wr_pin) begin
      next_r.pin_disable = reg_wdata;
    end
    if (wr_misc) begin
      next_r.conv_enable = reg_wdata[`ADCCTL_MISC_ENABLE];
      next_r.rc_freq = reg_wdata[`ADCCTL_MISC_RC_FREQ];
    end
    // launch: done must be clear now or cleared by this same write
    if (start_req && !r.start_busy && (!r.done || (wr_ctrl && !reg_wdata[`ADCCTL_CTRL_DONE]))) begin
      next_r.start_busy = 1'b1;
      next_r.state = adcctl_pkg::ADCCTL_CONVERT;
      next_r.ticks = `ADCCTL_TICK_ZERO;
    end else if (r.start_busy && !(wr_ctrl && !reg_wdata[`ADCCTL_CTRL_START])) begin
      unique case (r.state)
        adcctl_pkg::ADCCTL_CONVERT: begin
          if (r.conv_clk_tick) begin
            next_r.ticks = r.ticks + `ADCCTL_TICK_ONE;
          end
          if (core_ready || (r.ticks == `ADCCTL_CONV_TICKS)) begin
            next_r.sample = core_result;
            next_r.state = adcctl_pkg::ADCCTL_FINISH;
          end
        end
        adcctl_pkg::ADCCTL_FINISH: begin
          next_r.result = r.sample;
          next_r.done = 1'b1;
          next_r.start_busy = 1'b0;
          next_r.state = adcctl_pkg::ADCCTL_IDLE;
        end
        adcctl_pkg::ADCCTL_IDLE: begin
          next_r.state = adcctl_pkg::ADCCTL_IDLE;
        end
      endcase
    end
    // read mux
    if (reg_rd) begin
      unique case (reg_addr)
        `ADCCTL_OFS_CTRL: next_r.rd_data = {r.result[1:0], r.ext_trig_en, r.done, r.start_busy,
                                            r.clk_src, r.channel[1:0]};
        `ADCCTL_OFS_RESULT_HIGH: next_r.rd_data = r.result[9:2];
        `ADCCTL_OFS_CTRL_EXT: next_r.rd_data = {r.prescale, 3'h0, r.channel[2], 2'h0};
        `ADCCTL_OFS_PIN_DISABLE: next_r.rd_data = r.pin_disable;
        `ADCCTL_OFS_MISC: next_r.rd_data = {6'h00, r.rc_freq, r.conv_enable};
        default: next_r.rd_data = `ADCCTL_BYTE_ZERO;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.prescale <= `ADCCTL_PRESCALE_RESET;
      r.state <= adcctl_pkg::ADCCTL_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // outputs
  assign reg_rdata = r.rd_data;
  assign conv_tick = r.conv_clk_tick;
  assign conv_active = r.start_busy;
  assign conv_channel = r.channel;
  assign conv_rc_source = r.clk_src;
  assign conv_rc_fast = r.rc_freq;
  assign conv_irq_req = r.done;
  assign pin_digital_off = r.pin_disable;

  // checks
  property p_done_clears_busy;
    @(posedge core_clk) disable iff (!rst_n) $rose(r.done) |-> !r.start_busy;
  endproperty
  a_done_clears_busy: assert property (p_done_clears_busy) else $error("busy left high at done");

  property p_done_not_by_sw;
    @(posedge core_clk) disable iff (!rst_n) $rose(r.done) |-> $past(r.state) == adcctl_pkg::ADCCTL_FINISH;
  endproperty
  a_done_not_by_sw: assert property (p_done_not_by_sw) else $error("done set without completion");

  property p_no_start_when_done;
    @(posedge core_clk) disable iff (!rst_n)
      (r.done && !r.start_busy && !wr_ctrl) |=> !r.start_busy;
  endproperty
  a_no_start_when_done: assert property (p_no_start_when_done) else $error("start while done");

  property p_abort;
    @(posedge core_clk) disable iff (!rst_n)
      (r.start_busy && wr_ctrl && !reg_wdata[`ADCCTL_CTRL_START]) |=> !r.start_busy && !r.done;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");

  property p_clear_and_start;
    @(posedge core_clk) disable iff (!rst_n)
      (r.done && !r.start_busy && wr_ctrl && reg_wdata[`ADCCTL_CTRL_START] && !reg_wdata[`ADCCTL_CTRL_DONE])
      |=> r.start_busy && !r.done;
  endproperty
  a_clear_and_start: assert property (p_clear_and_start) else $error("fresh start lost");

  property p_clk_src_guard;
    @(posedge core_clk) disable iff (!rst_n) r.conv_enable |=> $stable(r.clk_src);
  endproperty
  a_clk_src_guard: assert property (p_clk_src_guard) else $error("source changed while enabled");

  property p_channel_guard;
    @(posedge core_clk) disable iff (!rst_n) (r.done || r.start_busy) |=> $stable(r.channel);
  endproperty
  a_channel_guard: assert property (p_channel_guard) else $error("channel changed while busy");

  property p_trigger_start;
    @(posedge core_clk) disable iff (!rst_n)
      (trig_edge && !r.start_busy && !r.done) |=> r.start_busy;
  endproperty
  a_trigger_start: assert property (p_trigger_start) else $error("trigger edge missed");

  property p_result_read;
    @(posedge core_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `ADCCTL_OFS_RESULT_HIGH) |=> reg_rdata == $past(r.result[9:2]);
  endproperty
  a_result_read: assert property (p_result_read) else $error("result high mismatch");

  // a software launch from the idle, flag-clear state
  sequence s_sw_launch;
    !r.start_busy && !r.done && wr_ctrl && reg_wdata[`ADCCTL_CTRL_START];
  endsequence

  // converter running in its convert state with done still low
  sequence s_running;
    r.start_busy && !r.done && (r.state == adcctl_pkg::ADCCTL_CONVERT);
  endsequence

  // software start from idle enters the convert state next cycle
  property p_sw_launch;
    @(posedge core_clk) disable iff (!rst_n)
      s_sw_launch |=> s_running;
  endproperty
  a_sw_launch: assert property (p_sw_launch) else $error("software start lost");

  // the finish step sets done and drops busy in one edge
  property p_finish_sets_done;
    @(posedge core_clk) disable iff (!rst_n)
      (r.start_busy && (r.state == adcctl_pkg::ADCCTL_FINISH) && !(wr_ctrl && !reg_wdata[`ADCCTL_CTRL_START]))
      |=> r.done && !r.start_busy;
  endproperty
  a_finish_sets_done: assert property (p_finish_sets_done) else $error("completion did not set done");

  // done flag holds until software writes zero to it
  property p_done_holds;
    @(posedge core_clk) disable iff (!rst_n)
      (r.done && !(wr_ctrl && !reg_wdata[`ADCCTL_CTRL_DONE])) |=> r.done;
  endproperty
  a_done_holds: assert property (p_done_holds) else $error("done dropped without clear");

  // busy stays high through the conversion unless aborted
  property p_busy_holds;
    @(posedge core_clk) disable iff (!rst_n)
      (r.start_busy && (r.state == adcctl_pkg::ADCCTL_CONVERT) && !(wr_ctrl && !reg_wdata[`ADCCTL_CTRL_START])) |=> r.start_busy;
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("busy dropped mid conversion");

  // both flags set never shows in the registers
  property p_no_both_flags;
    @(posedge core_clk) disable iff (!rst_n)
      !(r.done && r.start_busy);
  endproperty
  a_no_both_flags: assert property (p_no_both_flags) else $error("done and busy both visible");

  // without the trigger enable the pin alone starts nothing
  property p_trigger_off;
    @(posedge core_clk) disable iff (!rst_n)
      (!r.ext_trig_en && !r.start_busy && !(wr_ctrl && reg_wdata[`ADCCTL_CTRL_START])) |=> !r.start_busy;
  endproperty
  a_trigger_off: assert property (p_trigger_off) else $error("start without a request");

  // converter ticks only while the converter is enabled
  property p_tick_needs_enable;
    @(posedge core_clk) disable iff (!rst_n)
      !r.conv_enable |=> !r.conv_clk_tick;
  endproperty
  a_tick_needs_enable: assert property (p_tick_needs_enable) else $error("tick while disabled");

  // divide by one from the cpu clock ticks every cycle
  property p_div_one;
    @(posedge core_clk) disable iff (!rst_n)
      (r.conv_enable && !r.clk_src && (r.prescale == `ADCCTL_PRESCALE_DIV1)) |=> r.conv_clk_tick;
  endproperty
  a_div_one: assert property (p_div_one) else $error("divide by one missed a tick");

  // rc source ticks only on an rc oscillator edge
  property p_rc_gate;
    @(posedge core_clk) disable iff (!rst_n)
      (r.conv_enable && r.clk_src && !rc_clk_tick) |=> !r.conv_clk_tick;
  endproperty
  a_rc_gate: assert property (p_rc_gate) else $error("tick without rc edge");

  // pin disable outputs follow the written byte
  property p_pin_write;
    @(posedge core_clk) disable iff (!rst_n)
      wr_pin |=> pin_digital_off == $past(reg_wdata);
  endproperty
  a_pin_write: assert property (p_pin_write) else $error("pin disable not written");

  // low result bits read back in the main control register
  property p_result_low;
    @(posedge core_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `ADCCTL_OFS_CTRL) |=> reg_rdata[`ADCCTL_CTRL_RES_HI:`ADCCTL_CTRL_RES_LO] == $past(r.result[1:0]);
  endproperty
  a_result_low: assert property (p_result_low) else $error("result low bits mismatch");

  // read data stands one cycle only, zero otherwise
  property p_read_zero;
    @(posedge core_clk) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == `ADCCTL_BYTE_ZERO;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("read data without a read");

  // low channel bits reach the converter select when idle with done clear
  property p_channel_write;
    @(posedge core_clk) disable iff (!rst_n)
      (wr_ctrl && !r.done && !r.start_busy) |=> conv_channel[1:0] == $past(reg_wdata[`ADCCTL_CTRL_CH1:`ADCCTL_CTRL_CH0]);
  endproperty
  a_channel_write: assert property (p_channel_write) else $error("channel not taken");

endmodule // adcctl_top

// ### testbench/adcctl_core_model.sv
// analog converter core stand-in that answers after a set delay
`timescale 1ns/1ps
module adcctl_core_model (
  input wire logic core_clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic conv_active, // conversion running
  input wire logic [9:0] sample, // value the next conversion yields
  input wire logic [7:0] delay, // cycles until the answer
  output logic [9:0] core_result, // result to the control block
  output logic core_ready // result valid
);
  logic [7:0] cnt;
  // answer held until the run ends, then the result lines carry inverted junk
  always @(posedge core_clk) begin
    if (!rst_n || !conv_active) begin
      cnt <= 8'h00;
      core_ready <= 1'b0;
      core_result <= ~sample;
    end else if (cnt == delay) begin
      core_ready <= 1'b1;
      core_result <= sample;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // adcctl_core_model

// ### testbench/adcctl_top_bench.sv
// self-checking bench of the conversion control block
`timescale 1ns/1ps
`include "adcctl_defines.svh"
module adcctl_top_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rc_clk_tick = 1'b0;
  logic trig = 1'b0;
  logic [9:0] sample = 10'h000;
  logic [7:0] delay = 8'h10;
  logic [7:0] reg_rdata, pin_digital_off;
  logic [9:0] core_result;
  logic core_ready, conv_tick, conv_active, conv_rc_source, conv_rc_fast, conv_irq_req;
  logic [2:0] conv_channel;
  logic [7:0] amap [6] = '{8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hF6, 8'h10};
  integer seed = 32'hb03b;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int n, i, e;
  int m_done, m_busy, m_ext, m_src, m_ch, m_res, m_pin, m_en, m_fast;
  int m_pre = 2;
  adcctl_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rc_clk_tick(rc_clk_tick),
    .external_trigger_pin(trig), .core_result(core_result), .core_ready(core_ready), .conv_tick(conv_tick),
    .conv_active(conv_active), .conv_channel(conv_channel), .conv_rc_source(conv_rc_source),
    .conv_rc_fast(conv_rc_fast), .conv_irq_req(conv_irq_req), .pin_digital_off(pin_digital_off));
  adcctl_core_model u_core (.core_clk(core_clk), .rst_n(rst_n), .conv_active(conv_active), .sample(sample),
    .delay(delay), .core_result(core_result), .core_ready(core_ready));
  // clock, rc tick every other cycle, and hang ceiling
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    rc_clk_tick <= ~rc_clk_tick;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("summary: %0d comparisons, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // register write, mirrored into the reference model
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int od, ob;
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    od = m_done;
    ob = m_busy;
    if (a == `ADCCTL_OFS_MISC) m_en = d[0];
    if (a == `ADCCTL_OFS_MISC) m_fast = d[1];
    if (a == `ADCCTL_OFS_PIN_DISABLE) m_pin = d;
    if (a == `ADCCTL_OFS_CTRL_EXT) m_pre = d[7:6];
    if (a == `ADCCTL_OFS_CTRL_EXT && !od && !ob) m_ch[2] = d[2];
    if (a == `ADCCTL_OFS_CTRL) begin
      m_ext = d[5];
      if (!d[4]) m_done = 0;
      if (!m_en) m_src = d[2];
      if (!od && !ob) m_ch[1:0] = d[1:0];
      if (d[3] && !m_done) m_busy = 1;
      if (!d[3]) m_busy = 0;
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      `ADCCTL_OFS_CTRL: return {m_res[1:0], m_ext[0], m_done[0], m_busy[0], m_src[0], m_ch[1:0]};
      `ADCCTL_OFS_RESULT_HIGH: return m_res[9:2];
      `ADCCTL_OFS_CTRL_EXT: return {m_pre[1:0], 3'h0, m_ch[2], 2'h0};
      `ADCCTL_OFS_MISC: return {6'h00, m_fast[0], m_en[0]};
      `ADCCTL_OFS_PIN_DISABLE: return m_pin[7:0];
      default: return 8'h00;
    endcase
  endfunction
  task automatic rd_check(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    cmp({8'h00, reg_rdata}, {8'h00, exp_rd(a)}, "register read");
  endtask
  task automatic out_check();
    repeat (2) @(negedge core_clk);
    cmp({1'b0, conv_active, conv_irq_req, conv_channel, conv_rc_source, conv_rc_fast, pin_digital_off},
      {1'b0, m_busy[0], m_done[0], m_ch[2:0], m_src[0], m_fast[0], m_pin[7:0]}, "port state");
  endtask
  task automatic start(input logic [7:0] c);
    @(posedge core_clk);
    sample <= 10'($random(seed));
    delay <= 8'h10 + 8'($random(seed) & 15);
    wr(`ADCCTL_OFS_CTRL, c);
    out_check();
  endtask
  task automatic finish();
    for (n = 0; n < 200 && conv_irq_req !== 1'b1; n++) @(negedge core_clk);
    m_done = 1;
    m_busy = 0;
    m_res = sample;
    out_check();
    rd_check(`ADCCTL_OFS_RESULT_HIGH);
    rd_check(`ADCCTL_OFS_CTRL);
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++) rd_check(amap[i]);
    wr(`ADCCTL_OFS_CTRL, 8'h10);
    out_check();
    $display("test reset values done");
    wr(`ADCCTL_OFS_PIN_DISABLE, 8'($random(seed)));
    for (i = 0; i < 8; i++) begin
      wr(`ADCCTL_OFS_CTRL_EXT, {5'h10, i[2], 2'h0});
      wr(`ADCCTL_OFS_CTRL, {6'h00, i[1:0]});
      out_check();
    end
    wr(`ADCCTL_OFS_MISC, 8'h03);
    wr(`ADCCTL_OFS_CTRL, 8'h04);
    out_check();
    wr(`ADCCTL_OFS_MISC, 8'h00);
    wr(`ADCCTL_OFS_CTRL, 8'h04);
    out_check();
    $display("test channels and clock source done");
    for (i = 0; i < 5; i++) begin
      wr(`ADCCTL_OFS_MISC, 8'h00);
      wr(`ADCCTL_OFS_CTRL, (i == 4) ? 8'h04 : 8'h00);
      wr(`ADCCTL_OFS_CTRL_EXT, {i[1:0], 6'h00});
      wr(`ADCCTL_OFS_MISC, 8'h01);
      e = (i == 4) ? 32 : (64 >> i);
      n = 0;
      repeat (64) @(negedge core_clk) if (conv_tick === 1'b1) n++;
      cmp({15'h0000, (n - e <= 1 && e - n <= 1)}, 16'h0001, "tick count");
    end
    wr(`ADCCTL_OFS_MISC, 8'h00);
    wr(`ADCCTL_OFS_CTRL, 8'h00);
    $display("test prescaler done");
    start(8'h09);
    wr(`ADCCTL_OFS_CTRL, 8'h0A);
    out_check();
    finish();
    wr(`ADCCTL_OFS_CTRL, 8'h1A);
    out_check();
    start(8'h0A);
    finish();
    wr(`ADCCTL_OFS_CTRL, 8'h00);
    start(8'h08);
    wr(`ADCCTL_OFS_CTRL, 8'h00);
    repeat (50) @(negedge core_clk);
    out_check();
    $display("test conversions done");
    @(posedge core_clk);
    trig <= 1'b1;
    repeat (6) @(negedge core_clk);
    out_check();
    @(posedge core_clk);
    trig <= 1'b0;
    start(8'h20);
    @(posedge core_clk);
    trig <= 1'b1;
    repeat (6) @(negedge core_clk);
    m_busy = 1;
    out_check();
    finish();
    $display("test trigger done");
    end_of_test();
  end
endmodule // adcctl_top_bench
